// ### rtl/scs_synth_ctrl.v
// Synthesizer calibration sequencing, channel selection and lock events.
`timescale 1ns/10ps
`include "scs_consts.vh"

// Functional notes
// - Leaving radio-off for synth-on, listen, ext-TX or ext-RX starts both calibrations.
// - A change of frequency setting in synth-on, listen, ext-TX or ext-RX starts both calibrations.
// - Writing one to centre-frequency start bit begins that calibration.
// - Centre-frequency value steps by one every 8 us, 1 to 3 steps.
// - Finished centre-frequency calibration raises the lock event.
// - Delay-cell start runs a 6 us successive approximation, ignoring contents.
// - Calibration is allowed in every state, receive and transmit included.
// - Both calibrations run independently and concurrently.
// - Lock on locking, unlock on unexpected loss; each clears the other.
// - Lock after radio-off exit, frequency change, or manual calibration end.
// - Unlock on manual calibration start or frequency change in synth-on/listen.
// - Event in busy transmit states aborts and returns to synth-on.
// - Event in busy receive states returns to its receive state on lock.
// - No lock event during post-transmit settling.
// - Channel field bits 4:0, codes 0x0B..0x1A, 2405..2480 MHz, reset 0x0B.
// - Band field bits 3:0: zero standard, 0x8 and 0x9 alternate bands.
// - Alternate number picks 0.5 MHz steps within the selected band.
// - Band 0x8 is 2306 MHz plus half number; band 0x9 2434 MHz plus.
// - Start bits read one while running and clear when done.
// - Both start bits sit at bit 7 of their calibration registers.
module scs_synth_ctrl (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Register port
   input wire [5:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   output reg [7:0] regRdData_ff,
   // Transceiver state machine
   input wire [3:0] trxState,
   input wire txSettle,
   output reg forceReq_ff,
   output reg [3:0] forceState_ff,
   // Analog synthesizer
   input wire pllLockPin,
   input wire [3:0] cfTarget,
   input wire dcHigh,
   output reg [12:0] freqCode_ff,
   output reg [3:0] cfVal_ff,
   output reg [3:0] dcVal_ff,
   output reg cfBusy_ff,
   output reg dcBusy_ff,
   // Events and interrupt
   input wire lockMaskEn,
   input wire unlockMaskEn,
   input wire pendClr,
   output reg lockEvt_ff,
   output reg unlockEvt_ff,
   output reg lockPend_ff,
   output reg unlockPend_ff,
   output reg irq_ff
);

   // ==============================================================
   // Registers
   reg [7:0] chanReg_ff;
   reg [7:0] altNum_ff;
   reg [3:0] altBand_ff;
   reg [2:0] cfSpare_ff;
   reg [7:0] dcReg_ff;
   reg [3:0] stPrev_ff;
   reg freqValid_ff;
   reg lockWant_ff;
   reg rxReturn_ff;
   reg [3:0] rxTarget_ff;
   reg [7:0] cfCnt_ff;
   reg [1:0] cfSteps_ff;
   reg [7:0] dcCnt_ff;
   reg [3:0] dcMask_ff;
   reg [2:0] lockSync_ff;
   reg lockLvl_ff;

   wire wrCf = regWrEn && regAddr == `SCS_ADDR_CFCAL;
   wire wrDc = regWrEn && regAddr == `SCS_ADDR_DCCAL;
   wire manCf = wrCf && regWrData[`SCS_CAL_START_BIT];
   wire manDc = wrDc && regWrData[`SCS_CAL_START_BIT];
   wire inSynthListen = trxState == `SCS_ST_SYNTH_ON || trxState == `SCS_ST_LISTEN;
   wire inOnStates = inSynthListen || trxState == `SCS_ST_EXT_TX ||
      trxState == `SCS_ST_EXT_RX;

   // ==============================================================
   // Frequency selection
   wire [4:0] chanOff = chanReg_ff[4:0] - `SCS_CH_FIRST;
   reg [12:0] nxt_freq;
   always @* begin
      case (altBand_ff)
         `SCS_BAND_LOW: nxt_freq = `SCS_F_BAND_LOW + {5'h00, altNum_ff};
         `SCS_BAND_HIGH: nxt_freq = `SCS_F_BAND_HIGH + {5'h00, altNum_ff};
         // Reserved bands fall back to the channel field.
         default: nxt_freq = `SCS_F_CH_FIRST + {8'h00, chanOff} * `SCS_F_CH_STEP;
      endcase
   end

   wire offExit = stPrev_ff == `SCS_ST_OFF && inOnStates;
   wire freqChg = freqValid_ff && inOnStates && nxt_freq != freqCode_ff;
   wire autoStart = (offExit && inSynthListen) || freqChg;
   wire anyCfStart = autoStart || manCf || offExit;
   wire anyDcStart = autoStart || manDc || offExit;

   // ==============================================================
   // Lock input, three-stage synchroniser
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lockSync_ff <= 3'h0;
         lockLvl_ff <= 1'b0;
      end else begin
         lockSync_ff <= {lockSync_ff[1:0], pllLockPin};
         if (lockSync_ff[1] == lockSync_ff[2]) begin
            lockLvl_ff <= lockSync_ff[2];
         end
      end
   end
   wire lockLvlNew = (lockSync_ff[1] == lockSync_ff[2]) ? lockSync_ff[2] : lockLvl_ff;
   wire lockRise = lockLvlNew && !lockLvl_ff;
   wire lockFall = !lockLvlNew && lockLvl_ff;

   // ==============================================================
   // Centre-frequency calibration: one step per 8 us period.
   wire cfStepEnd = cfBusy_ff && cfCnt_ff == `SCS_CF_STEP_LAST;
   reg [3:0] cfNext;
   always @* begin
      cfNext = cfVal_ff;
      if (cfVal_ff < cfTarget) begin
         cfNext = cfVal_ff + 4'h1;
      end else if (cfVal_ff > cfTarget) begin
         cfNext = cfVal_ff - 4'h1;
      end
   end
   wire cfDone = cfStepEnd &&
      (cfNext == cfTarget || cfSteps_ff == `SCS_CF_MAX_STEPS - 2'h1);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfBusy_ff <= 1'b0;
         cfCnt_ff <= 8'h00;
         cfSteps_ff <= 2'h0;
         cfVal_ff <= 4'h7;
         cfSpare_ff <= 3'h5;
      end else begin
         if (wrCf) begin
            cfSpare_ff <= regWrData[6:4];
         end
         // A start during a running calibration restarts it.
         if (anyCfStart) begin
            cfBusy_ff <= 1'b1;
            cfCnt_ff <= 8'h00;
            cfSteps_ff <= 2'h0;
            if (wrCf) begin
               cfVal_ff <= regWrData[3:0];
            end
         end else if (wrCf && !cfBusy_ff) begin
            cfVal_ff <= regWrData[3:0];
         end else if (cfBusy_ff) begin
            cfCnt_ff <= cfStepEnd ? 8'h00 : cfCnt_ff + 8'h01;
            if (cfStepEnd) begin
               cfVal_ff <= cfNext;
               cfSteps_ff <= cfSteps_ff + 2'h1;
            end
            if (cfDone) begin
               cfBusy_ff <= 1'b0;
            end
         end
      end
   end

   // ==============================================================
   // Delay-cell calibration: four approximation steps over 6 us.
   wire dcStepEnd = dcBusy_ff && dcCnt_ff == `SCS_DC_BIT_LAST;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dcBusy_ff <= 1'b0;
         dcCnt_ff <= 8'h00;
         dcMask_ff <= 4'h0;
         dcVal_ff <= 4'h8;
         dcReg_ff <= `SCS_RST_DCCAL;
      end else begin
         if (wrDc) begin
            dcReg_ff <= {1'b0, dcReg_ff[`SCS_DC_RO_BIT], regWrData[5:0]};
         end
         if (anyDcStart) begin
            // Register contents play no part in the search.
            dcBusy_ff <= 1'b1;
            dcCnt_ff <= 8'h00;
            dcMask_ff <= 4'h8;
            dcVal_ff <= 4'h8;
         end else if (dcBusy_ff) begin
            dcCnt_ff <= dcStepEnd ? 8'h00 : dcCnt_ff + 8'h01;
            if (dcStepEnd) begin
               dcVal_ff <= (dcHigh ? dcVal_ff & ~dcMask_ff : dcVal_ff) |
                  (dcMask_ff >> 1);
               dcMask_ff <= dcMask_ff >> 1;
               if (dcMask_ff == 4'h1) begin
                  dcBusy_ff <= 1'b0;
               end
            end
         end
      end
   end

   // ==============================================================
   // Lock and unlock events
   wire calBusy = cfBusy_ff || dcBusy_ff;
   wire cfFinish = cfDone && !anyCfStart;
   wire nxt_lockEvt = !txSettle && ((cfFinish && lockWant_ff) ||
      (lockRise && !calBusy && !lockWant_ff));
   wire nxt_unlockEvt = ((manCf || freqChg) && inSynthListen) ||
      (lockFall && !calBusy && !lockWant_ff);
   wire busyTx = trxState == `SCS_ST_BUSY_TX || trxState == `SCS_ST_BUSY_EXT_TX;
   wire busyRx = trxState == `SCS_ST_BUSY_RX || trxState == `SCS_ST_BUSY_EXT_RX;
   wire anyEvt = nxt_lockEvt || nxt_unlockEvt;
   // A new event clears the opposite flag; a set beats a software clear.
   wire nxt_lockPend = nxt_lockEvt || (lockPend_ff && !pendClr && !nxt_unlockEvt);
   wire nxt_unlockPend = (nxt_unlockEvt && !nxt_lockEvt) ||
      (unlockPend_ff && !pendClr && !nxt_lockEvt);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lockEvt_ff <= 1'b0;
         unlockEvt_ff <= 1'b0;
         lockPend_ff <= 1'b0;
         unlockPend_ff <= 1'b0;
         irq_ff <= 1'b0;
         lockWant_ff <= 1'b0;
         forceReq_ff <= 1'b0;
         forceState_ff <= `SCS_ST_OFF;
         rxReturn_ff <= 1'b0;
         rxTarget_ff <= `SCS_ST_LISTEN;
      end else begin
         lockEvt_ff <= nxt_lockEvt;
         unlockEvt_ff <= nxt_unlockEvt && !nxt_lockEvt;
         lockPend_ff <= nxt_lockPend;
         unlockPend_ff <= nxt_unlockPend;
         irq_ff <= (nxt_lockPend && lockMaskEn) || (nxt_unlockPend && unlockMaskEn);
         if (anyCfStart) begin
            lockWant_ff <= 1'b1;
         end else if (cfFinish) begin
            lockWant_ff <= 1'b0;
         end
         forceReq_ff <= 1'b0;
         if (anyEvt && busyTx) begin
            forceReq_ff <= 1'b1;
            forceState_ff <= `SCS_ST_SYNTH_ON;
         end else if (rxReturn_ff && nxt_lockEvt) begin
            forceReq_ff <= 1'b1;
            forceState_ff <= rxTarget_ff;
            rxReturn_ff <= 1'b0;
         end else if (anyEvt && busyRx) begin
            rxReturn_ff <= 1'b1;
            rxTarget_ff <= (trxState == `SCS_ST_BUSY_RX) ?
               `SCS_ST_LISTEN : `SCS_ST_EXT_RX;
         end
      end
   end

   // ==============================================================
   // Register file and frequency tracking
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chanReg_ff <= `SCS_RST_CHAN;
         altNum_ff <= `SCS_RST_ALTNUM;
         altBand_ff <= `SCS_RST_ALTBAND;
         freqCode_ff <= `SCS_F_CH_FIRST;
         freqValid_ff <= 1'b0;
         stPrev_ff <= `SCS_ST_OFF;
         regRdData_ff <= 8'h00;
      end else begin
         stPrev_ff <= trxState;
         freqCode_ff <= nxt_freq;
         freqValid_ff <= 1'b1;
         if (regWrEn) begin
            case (regAddr)
               `SCS_ADDR_CHAN: chanReg_ff <= regWrData;
               `SCS_ADDR_ALTNUM: altNum_ff <= regWrData;
               `SCS_ADDR_ALTBAND: altBand_ff <= regWrData[3:0];
               default: ;
            endcase
         end
         if (regRdEn) begin
            case (regAddr)
               `SCS_ADDR_CHAN: regRdData_ff <= chanReg_ff;
               `SCS_ADDR_ALTNUM: regRdData_ff <= altNum_ff;
               `SCS_ADDR_ALTBAND: regRdData_ff <= {4'h0, altBand_ff};
               `SCS_ADDR_CFCAL: regRdData_ff <= {cfBusy_ff, cfSpare_ff, cfVal_ff};
               `SCS_ADDR_DCCAL: regRdData_ff <= {dcBusy_ff, dcReg_ff[6:0]};
               default: regRdData_ff <= 8'h00;
            endcase
         end
      end
   end

endmodule // scs_synth_ctrl

// ### rtl/scs_consts.vh
// Constants of the synthesizer calibration and channel select block.
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH
// ==============================================================
// Register offsets and reset values
`define SCS_ADDR_CHAN 6'h08
`define SCS_ADDR_ALTNUM 6'h13
`define SCS_ADDR_ALTBAND 6'h14
`define SCS_ADDR_CFCAL 6'h1A
`define SCS_ADDR_DCCAL 6'h1B
`define SCS_RST_CHAN 8'h0B
`define SCS_RST_ALTNUM 8'h00
`define SCS_RST_ALTBAND 4'h0
`define SCS_RST_CFCAL 8'h57
`define SCS_RST_DCCAL 8'h20
`define SCS_CAL_START_BIT 7
`define SCS_DC_RO_BIT 6
// ==============================================================
// Frequency selection, in units of 0.5 MHz
`define SCS_BAND_STD 4'h0
`define SCS_BAND_LOW 4'h8
`define SCS_BAND_HIGH 4'h9
`define SCS_CH_FIRST 5'h0B
`define SCS_F_CH_FIRST 13'h12CA
`define SCS_F_CH_STEP 13'h000A
`define SCS_F_BAND_LOW 13'h1204
`define SCS_F_BAND_HIGH 13'h1304
// ==============================================================
// Transceiver state codes
`define SCS_ST_OFF 4'h0
`define SCS_ST_SYNTH_ON 4'h1
`define SCS_ST_LISTEN 4'h2
`define SCS_ST_EXT_TX 4'h3
`define SCS_ST_EXT_RX 4'h4
`define SCS_ST_BUSY_TX 4'h5
`define SCS_ST_BUSY_EXT_TX 4'h6
`define SCS_ST_BUSY_RX 4'h7
`define SCS_ST_BUSY_EXT_RX 4'h8
// ==============================================================
// Timing
`define SCS_CLK_NS 50
`define SCS_T_CF_STEP_NS 8000
`define SCS_T_DC_CAL_NS 6000
`define SCS_CF_MAX_STEPS 2'h3
`define SCS_CF_STEP_CYC ((`SCS_T_CF_STEP_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_DC_BIT_CYC ((`SCS_T_DC_CAL_NS / 4) / `SCS_CLK_NS)
`define SCS_CF_STEP_LAST 8'h9F
`define SCS_DC_BIT_LAST 8'h1D
`endif

// ### dv/scs_synth_monitor.sv
// Port checker of the synthesizer calibration block.
`timescale 1ns/10ps
module scs_synth_monitor (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Observed design ports
   input wire [5:0] regAddr,
   input wire regRdEn,
   input wire [7:0] regRdData_ff,
   input wire [3:0] trxState,
   input wire txSettle,
   input wire forceReq_ff,
   input wire [3:0] forceState_ff,
   input wire [3:0] cfVal_ff,
   input wire cfBusy_ff,
   input wire dcBusy_ff,
   input wire lockEvt_ff,
   input wire unlockEvt_ff,
   input wire lockPend_ff,
   input wire unlockPend_ff,
   input wire irq_ff
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ==========================================
   // Busy run counters
   // A restart merges two runs, so starts must be spaced apart.
   reg [9:0] cfRun_ff;
   reg [9:0] dcRun_ff;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfRun_ff <= 10'h000;
         dcRun_ff <= 10'h000;
      end else begin
         cfRun_ff <= cfBusy_ff ? cfRun_ff + 10'h001 : 10'h000;
         dcRun_ff <= dcBusy_ff ? dcRun_ff + 10'h001 : 10'h000;
      end
   end
   // ==========================================
   // Properties
   sequence rdCal;
      regRdEn && regAddr == 6'h1A;
   endsequence
   sequence rdFree;
      regRdEn && regAddr > 6'h1B;
   endsequence
   cal_readback_a: assert property (rdCal |=> regRdData_ff[7] == $past(cfBusy_ff)
      && regRdData_ff[3:0] == $past(cfVal_ff)) else $error("calibration readback wrong");
   free_read_a: assert property (rdFree |=> regRdData_ff == 8'h00)
      else $error("unmapped read not zero");
   cf_length_a: assert property ($fell(cfBusy_ff) |-> cfRun_ff >= 10'h09F && cfRun_ff <= 10'h1E1)
      else $error("centre calibration length wrong");
   dc_length_a: assert property ($fell(dcBusy_ff) |-> dcRun_ff == 10'h078)
      else $error("delay calibration length wrong");
   cf_end_lock_a: assert property ($fell(cfBusy_ff) && !txSettle && !$past(txSettle) |-> lockEvt_ff)
      else $error("no lock event at calibration end");
   settle_quiet_a: assert property (txSettle && $past(txSettle) |-> !lockEvt_ff)
      else $error("lock event while settling");
   evt_apart_a: assert property (!(lockEvt_ff && unlockEvt_ff))
      else $error("lock and unlock together");
   lock_clears_a: assert property (lockEvt_ff ##1 !unlockEvt_ff |-> !unlockPend_ff)
      else $error("lock left unlock pending");
   unlock_clears_a: assert property (unlockEvt_ff ##1 !lockEvt_ff |-> !lockPend_ff)
      else $error("unlock left lock pending");
   tx_abort_a: assert property ((lockEvt_ff || unlockEvt_ff) && trxState inside {4'h5, 4'h6}
      && $stable(trxState) |-> ##[0:2] forceReq_ff && forceState_ff == 4'h1) else $error("no abort");
   irq_cause_a: assert property (irq_ff |-> lockPend_ff || unlockPend_ff
      || $past(lockPend_ff) || $past(unlockPend_ff)) else $error("interrupt without pending");
endmodule // scs_synth_monitor
bind scs_synth_ctrl scs_synth_monitor mon (.clk, .nrst, .regAddr, .regRdEn, .regRdData_ff,
   .trxState, .txSettle, .forceReq_ff, .forceState_ff, .cfVal_ff, .cfBusy_ff, .dcBusy_ff,
   .lockEvt_ff, .unlockEvt_ff, .lockPend_ff, .unlockPend_ff, .irq_ff);

// ### dv/scs_tb.sv
// Self-checking bench of the synthesizer calibration block.
`timescale 1ns/10ps
module tb;
   // ==========================================
   // Ports and bench state
   reg clk = 1'h0, nrst = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0, txSettle = 1'h0, pllLockPin = 1'h1;
   reg dcHigh = 1'h0, lockMaskEn = 1'h0, unlockMaskEn = 1'h0, pendClr = 1'h0;
   reg [5:0] regAddr = 6'h00;
   reg [7:0] regWrData = 8'h00, d;
   reg [3:0] trxState = 4'h0, cfTarget = 4'h7, lastF;
   wire [7:0] regRdData_ff;
   wire [12:0] freqCode_ff;
   wire [3:0] forceState_ff, cfVal_ff, dcVal_ff;
   wire forceReq_ff, cfBusy_ff, dcBusy_ff, lockEvt_ff, unlockEvt_ff, lockPend_ff, unlockPend_ff, irq_ff;
   integer errCount = 0, totalChecks = 0, cycles = 0, fCnt = 0, lCnt = 0;
   integer seed, i, n, t, c, nb, num, r, dcThr;
   localparam [83:0] RT = {6'h3F, 8'h00, 6'h1B, 8'h20, 6'h1A, 8'h57, 6'h14, 8'h00, 6'h13, 8'h00,
      6'h08, 8'h0B};
   scs_synth_ctrl uut (.clk, .nrst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_ff,
      .trxState, .txSettle, .forceReq_ff, .forceState_ff, .pllLockPin, .cfTarget, .dcHigh,
      .freqCode_ff, .cfVal_ff, .dcVal_ff, .cfBusy_ff, .dcBusy_ff, .lockMaskEn, .unlockMaskEn,
      .pendClr, .lockEvt_ff, .unlockEvt_ff, .lockPend_ff, .unlockPend_ff, .irq_ff);
   always #25 clk = ~clk;
   // The delay comparator is modelled as an ideal threshold on the trial value.
   always @(negedge clk) dcHigh <= dcVal_ff > dcThr;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (forceReq_ff === 1'h1) begin
         fCnt <= fCnt + 1;
         lastF <= forceState_ff;
      end
      if (lockEvt_ff === 1'h1) lCnt <= lCnt + 1;
      if (cycles == 30000) begin
         errCount = errCount + 1;
         testDone;
      end
   end
   // ==========================================
   // Model and bus tasks
   function integer refF(input integer ch, input integer b, input integer m);
      refF = b == 8 ? 4612 + m : b == 9 ? 4868 + m : 4810 + 10 * (ch - 11);
   endfunction
   task chk(input [15:0] g, input [15:0] e);
      begin
         totalChecks = totalChecks + 1;
         if (g !== e) begin
            errCount = errCount + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task wr(input [5:0] a, input [7:0] v);
      begin
         @(negedge clk);
         regAddr = a;
         regWrData = v;
         regWrEn = 1'h1;
         @(negedge clk);
         regWrEn = 1'h0;
      end
   endtask
   task rd(input [5:0] a);
      begin
         @(negedge clk);
         regAddr = a;
         regRdEn = 1'h1;
         @(negedge clk);
         regRdEn = 1'h0;
         d = regRdData_ff;
      end
   endtask
   task idle;
      begin
         n = 0;
         repeat (4) @(negedge clk);
         while ((cfBusy_ff | dcBusy_ff) !== 1'h0 && n < 2000) begin
            @(negedge clk);
            n = n + 1;
         end
         chk(n < 2000, 1);
      end
   endtask
   task waitLock(input v);
      begin
         pllLockPin = v;
         repeat (10) @(negedge clk);
      end
   endtask
   task testDone;
      begin
         $display("checks %0d mismatches %0d", totalChecks, errCount);
         if (errCount == 0 && totalChecks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ==========================================
   // Scenarios
   initial begin
      seed = 32'hBD1D;
      dcThr = 5;
      repeat (3) @(negedge clk);
      nrst = 1'h1;
      for (i = 0; i < 6; i = i + 1) begin
         rd(RT[i * 14 + 8 +: 6]);
         chk(d, RT[i * 14 +: 8]);
      end
      trxState = 4'h1;
      idle;
      chk(lockPend_ff, 1);
      for (i = 0; i < 16; i = i + 1) begin
         c = 11 + (i + 1) % 16;
         wr(6'h08, c[7:0]);
         repeat (4) @(negedge clk);
         chk({lockPend_ff, unlockPend_ff}, 2'h1);
         idle;
         chk(freqCode_ff, refF(c, 0, 0));
         chk({lockPend_ff, unlockPend_ff}, 2'h2);
      end
      for (i = 0; i < 6; i = i + 1) begin
         nb = i < 3 ? 8 : i < 5 ? 9 : 3;
         num = i == 0 ? 32 : i == 3 ? 186 : i < 3 ? 32 + {$random(seed)} % 224 : {$random(seed)} % 187;
         wr(6'h13, num[7:0]);
         idle;
         wr(6'h14, 8'hF0 | nb[7:0]);
         idle;
         chk(freqCode_ff, refF(11, nb, num));
         rd(6'h14);
         chk(d, nb);
      end
      for (t = 1; t <= 3; t = t + 1) begin
         rd(6'h1A);
         cfTarget = d[3] ? d[3:0] - t : d[3:0] + t;
         wr(6'h1A, d | 8'h80);
         idle;
         chk(n + 5 <= 160 * t + 3 && n + 8 >= 160 * t, 1);
         rd(6'h1A);
         chk(d, {4'h5, cfTarget});
      end
      dcThr = {$random(seed)} % 16;
      r = $random(seed);
      txSettle = 1'h1;
      lockMaskEn = 1'h1;
      num = lCnt;
      wr(6'h1B, r[7:0] | 8'h80);
      wr(6'h1A, d | 8'h80);
      chk({cfBusy_ff, dcBusy_ff}, 2'h3);
      rd(6'h1B);
      chk(d[7], 1);
      idle;
      chk(dcVal_ff, dcThr);
      chk(lCnt, num);
      chk(irq_ff, 0);
      unlockMaskEn = 1'h1;
      repeat (3) @(negedge clk);
      chk(irq_ff, 1);
      pendClr = 1'h1;
      @(negedge clk);
      pendClr = 1'h0;
      repeat (3) @(negedge clk);
      chk({lockPend_ff, unlockPend_ff, irq_ff}, 3'h0);
      txSettle = 1'h0;
      trxState = 4'h5;
      num = fCnt;
      waitLock(1'h0);
      chk({fCnt, lastF}, {num + 1, 4'h1});
      trxState = 4'h1;
      waitLock(1'h1);
      trxState = 4'h8;
      num = fCnt;
      waitLock(1'h0);
      chk(fCnt, num);
      waitLock(1'h1);
      chk({fCnt, lastF}, {num + 1, 4'h4});
      trxState = 4'h7;
      wr(6'h1A, d | 8'h80);
      chk(cfBusy_ff, 1);
      idle;
      trxState = 4'h0;
      repeat (2) @(negedge clk);
      num = lCnt;
      trxState = 4'h3;
      repeat (2) @(negedge clk);
      chk({cfBusy_ff, dcBusy_ff}, 2'h3);
      idle;
      @(negedge clk);
      chk(lCnt, num + 1);
      trxState = 4'h6;
      num = fCnt;
      waitLock(1'h0);
      chk({fCnt, lastF}, {num + 1, 4'h1});
      trxState = 4'h2;
      waitLock(1'h1);
      wr(6'h08, 8'h0C);
      repeat (4) @(negedge clk);
      chk({lockPend_ff, unlockPend_ff}, 2'h1);
      idle;
      chk(lockPend_ff, 1);
      chk(freqCode_ff, refF(12, 3, 0));
      testDone;
   end
endmodule // tb
